// ### pkg/cspso_pkg.sv
// constants, types and register map of the shift, subtract and pointer execution block
// assumes a single 40 MHz clock and an AXI4-Lite master reaching the registers
// Function
// - borrow_difference_op writes destination minus source minus carry into destination
// - carry_force_op sets carry to one, all other flags unchanged
// - arith_right_shift_op shifts right, keeps bit seven, copies it into bit six
// - shift sets carry from bit zero, zero and sign from result, clears overflow
// - pointer_load_op decodes source bits one, zero: 10 first, 01 second, 00 both
// - single pointer selected takes source bits seven to three
// - both selected take bits seven to four; first bit three clear, second set
// - first pointer sits at index D6, second pointer at index D7
// - stop op halts cpu and system clocks and enters stop mode
// - all registers keep their contents while stopped
// - stop mode ends only by external reset or external interrupt
// - subtract adds two's complement of source, stores in destination, source kept
// - subtract sets carry on borrow, zero on zero, sign on negative result
// - overflow set when operand signs differ and result sign equals source sign
// - subtract always sets decimal-adjust flag to one
// - half-carry clear on low nibble carry, set on nibble borrow
// - borrow_difference_op updates flags exactly like plain subtract
package cspso_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_DST  = 10'h000;
   localparam logic [9:0] IDX_SRC  = 10'h001;
   localparam logic [9:0] IDX_CMD  = 10'h002;
   localparam logic [9:0] IDX_FLG  = 10'h003;
   localparam logic [9:0] IDX_STAT = 10'h004;
   localparam logic [9:0] IDX_RP0  = 10'h0D6;
   localparam logic [9:0] IDX_RP1  = 10'h0D7;

   localparam logic [7:0] RST_DST = 8'h00;
   localparam logic [7:0] RST_SRC = 8'h00;
   localparam logic [7:0] RST_FLG = 8'h00;
   localparam logic [7:0] RST_RP0 = 8'h00;
   localparam logic [7:0] RST_RP1 = 8'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [3:0] {
      OP_NOP  = 4'h0,
      OP_SUB  = 4'h1,
      OP_SBC  = 4'h2,
      OP_SCF  = 4'h3,
      OP_SRA  = 4'h4,
      OP_SRP  = 4'h5,
      OP_POINTER_FIRST_LOAD_OP = 4'h6,
      OP_POINTER_SECOND_LOAD_OP = 4'h7,
      OP_STOP = 4'h8
   } cspso_op_type;

   // flag byte: c z s v d h, two low bits read zero
   typedef struct packed {
      logic       c;
      logic       z;
      logic       s;
      logic       v;
      logic       d;
      logic       h;
      logic [1:0] rsv;
   } cspso_flags_type;

   typedef struct packed {
      logic [7:0]      res;
      logic            wr_dst;
      cspso_flags_type flg;
   } cspso_alu_type;

   typedef enum logic {
      ST_RUN  = 1'b0,
      ST_STOP = 1'b1
   } cspso_state_type;

endpackage : cspso_pkg

// ### rtl/cspso_alu.sv
// combinational result and flag computation for subtract, shift and carry ops
// assumes the caller registers the outputs
`timescale 1ns/1ps
`default_nettype none
module cspso_alu
   import cspso_pkg::*;
(
   input  wire cspso_op_type    op,
   input  wire logic [7:0]      dst,
   input  wire logic [7:0]      src,
   input  wire cspso_flags_type flg_in,
   output var  cspso_alu_type   out
);
   logic [8:0] diff;
   logic [4:0] lo;
   logic       cin;

   always_comb begin
      out = '{res: dst, wr_dst: 1'b0, flg: flg_in};
      cin = (op == OP_SBC) ? flg_in.c : 1'b0;
      // two's complement add of source, less carry for the borrow form
      diff = {1'b0, dst} + {1'b0, ~src} + {8'h00, ~cin};
      lo = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + {4'h0, ~cin};
      case (op)
         OP_SUB, OP_SBC: begin
            out.res    = diff[7:0];
            out.wr_dst = 1'b1;
            out.flg.c  = ~diff[8];
            out.flg.z  = (diff[7:0] == 8'h00);
            out.flg.s  = diff[7];
            out.flg.v  = (dst[7] != src[7]) && (diff[7] == src[7]);
            out.flg.d  = 1'b1;
            out.flg.h  = ~lo[4];
         end
         OP_SCF: begin
            out.flg.c = 1'b1;
         end
         OP_SRA: begin
            out.res    = {dst[7], dst[7:1]};
            out.wr_dst = 1'b1;
            out.flg.c  = dst[0];
            out.flg.z  = (dst[7:1] == 7'h00) && !dst[7];
            out.flg.s  = dst[7];
            out.flg.v  = 1'b0;
         end
         default: begin
            out.wr_dst = 1'b0;
         end
      endcase
   end
endmodule : cspso_alu
`default_nettype wire

// ### rtl/cspso_core.sv
// execution block for subtract, shift, carry, pointer load and stop ops
// assumes an AXI4-Lite master on aclk and a level external interrupt wake input
`timescale 1ns/1ps
`default_nettype none
module cspso_core
   import cspso_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              ext_irq,
   output logic                   cpu_clk_en,
   output logic                   sys_clk_en,
   output logic                   stopped
);

   // ****************************************
   // state
   // ****************************************
   logic [ADDR_W-1:0] awaddr_q;
   logic              aw_held_q;
   logic [7:0]        wdata_q;
   logic              wlane_q;
   logic              w_held_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [DATA_W-1:0] rdata_q;

   logic [7:0]        dst_q;
   logic [7:0]        src_q;
   cspso_flags_type   flg_q;
   logic [7:0]        rp0_q;
   logic [7:0]        rp1_q;
   cspso_op_type      last_op_q;
   cspso_state_type   state_q;

   // ****************************************
   // write decode
   // ****************************************
   logic [9:0]   wr_idx;
   logic         wr_go;
   logic         wr_map;
   logic         wr_do;
   logic         exec;
   cspso_op_type exec_op;
   cspso_alu_type alu;

   assign wr_idx = awaddr_q[ADDR_W-1:2];
   assign wr_go  = aw_held_q && w_held_q && !bvalid_q;
   assign wr_map = (wr_idx == IDX_DST) || (wr_idx == IDX_SRC) ||
                   (wr_idx == IDX_CMD) || (wr_idx == IDX_FLG) ||
                   (wr_idx == IDX_STAT) || (wr_idx == IDX_RP0) ||
                   (wr_idx == IDX_RP1);
   // nothing may change while stopped
   assign wr_do  = wr_go && wr_map && wlane_q && (state_q == ST_RUN);
   assign exec   = wr_do && (wr_idx == IDX_CMD);
   assign exec_op = cspso_op_type'(wdata_q[3:0]);

   // ****************************************
   // AXI write channels
   // ****************************************
   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready  = !w_held_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && !aw_held_q) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q  <= 8'h00;
         wlane_q  <= 1'b0;
      end else if (s_axi_wvalid && !w_held_q) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata[7:0];
         wlane_q  <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         if (!wr_map) begin
            bresp_q <= RESP_DECERR;
         end else if (state_q == ST_STOP) begin
            bresp_q <= RESP_SLVERR;
         end else begin
            bresp_q <= RESP_OKAY;
         end
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ****************************************
   // AXI read channels
   // ****************************************
   logic [9:0] rd_idx;

   assign rd_idx        = s_axi_araddr[ADDR_W-1:2];
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= '0;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= '0;
         case (rd_idx)
            IDX_DST:  rdata_q[7:0] <= dst_q;
            IDX_SRC:  rdata_q[7:0] <= src_q;
            IDX_CMD:  rdata_q[3:0] <= last_op_q;
            IDX_FLG:  rdata_q[7:0] <= flg_q;
            IDX_STAT: rdata_q[0]   <= (state_q == ST_STOP);
            IDX_RP0:  rdata_q[7:0] <= rp0_q;
            IDX_RP1:  rdata_q[7:0] <= rp1_q;
            default:  rresp_q      <= RESP_DECERR;
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ****************************************
   // arithmetic
   // ****************************************
   cspso_alu u_alu (
      .op     (exec_op),
      .dst    (dst_q),
      .src    (src_q),
      .flg_in (flg_q),
      .out    (alu)
   );

   // source operand is only ever written by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_q <= RST_SRC;
      end else if (wr_do && wr_idx == IDX_SRC) begin
         src_q <= wdata_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dst_q <= RST_DST;
      end else if (wr_do && wr_idx == IDX_DST) begin
         dst_q <= wdata_q;
      end else if (exec && alu.wr_dst) begin
         dst_q <= alu.res;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flg_q <= RST_FLG;
      end else if (wr_do && wr_idx == IDX_FLG) begin
         flg_q <= {wdata_q[7:2], 2'b00};
      end else if (exec) begin
         flg_q <= alu.flg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_op_q <= OP_NOP;
      end else if (exec) begin
         last_op_q <= exec_op;
      end
   end

   // ****************************************
   // register window pointers
   // ****************************************
   logic srp_exec;

   assign srp_exec = exec && (exec_op == OP_SRP || exec_op == OP_POINTER_FIRST_LOAD_OP ||
                              exec_op == OP_POINTER_SECOND_LOAD_OP);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rp0_q <= RST_RP0;
         rp1_q <= RST_RP1;
      end else if (wr_do && wr_idx == IDX_RP0) begin
         rp0_q <= wdata_q;
      end else if (wr_do && wr_idx == IDX_RP1) begin
         rp1_q <= wdata_q;
      end else if (srp_exec) begin
         case (src_q[1:0])
            2'b10: rp0_q[7:3] <= src_q[7:3];
            2'b01: rp1_q[7:3] <= src_q[7:3];
            2'b00: begin
               rp0_q[7:3] <= {src_q[7:4], 1'b0};
               rp1_q[7:3] <= {src_q[7:4], 1'b1};
            end
            default: begin
               rp0_q <= rp0_q;
            end
         endcase
      end
   end

   // ****************************************
   // stop mode
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_RUN;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (exec && exec_op == OP_STOP) begin
                  state_q <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (ext_irq) begin
                  state_q <= ST_RUN;
               end
            end
            default: state_q <= ST_RUN;
         endcase
      end
   end

   assign cpu_clk_en = (state_q == ST_RUN);
   assign sys_clk_en = (state_q == ST_RUN);
   assign stopped    = (state_q == ST_STOP);

   // ****************************************
   // checks
   // ****************************************
   logic [7:0]      pd_q;
   logic [7:0]      ps_q;
   cspso_flags_type pf_q;
   logic            pe_q;
   cspso_op_type    pop_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pd_q  <= 8'h00;
         ps_q  <= 8'h00;
         pf_q  <= RST_FLG;
         pe_q  <= 1'b0;
         pop_q <= OP_NOP;
      end else begin
         pd_q  <= dst_q;
         ps_q  <= src_q;
         pf_q  <= flg_q;
         pe_q  <= exec;
         pop_q <= exec_op;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_sub_result: assert property (
      pe_q && pop_q == OP_SUB |-> dst_q == 8'(pd_q - ps_q) && src_q == ps_q)
      else $error("subtract result wrong");

   a_sbc_result: assert property (
      pe_q && pop_q == OP_SBC |-> dst_q == 8'(pd_q - ps_q - {7'h00, pf_q.c}))
      else $error("borrow difference result wrong");

   a_sub_flags: assert property (
      pe_q && (pop_q == OP_SUB || pop_q == OP_SBC) |->
      flg_q.z == (dst_q == 8'h00) && flg_q.s == dst_q[7] && flg_q.d)
      else $error("subtract flags wrong");

   a_sub_ovf: assert property (
      pe_q && pop_q == OP_SUB |->
      flg_q.v == ((pd_q[7] != ps_q[7]) && (dst_q[7] == ps_q[7])))
      else $error("subtract overflow wrong");

   a_sub_borrow: assert property (
      pe_q && pop_q == OP_SUB |-> flg_q.c == (ps_q > pd_q) &&
      flg_q.h == (ps_q[3:0] > pd_q[3:0]))
      else $error("subtract borrow flags wrong");

   a_carry_force: assert property (
      pe_q && pop_q == OP_SCF |-> flg_q.c && flg_q[6:0] == pf_q[6:0])
      else $error("carry force changed other flags");

   a_sra_shift: assert property (
      pe_q && pop_q == OP_SRA |-> dst_q == {pd_q[7], pd_q[7:1]} &&
      flg_q.c == pd_q[0] && !flg_q.v && flg_q.d == pf_q.d)
      else $error("arithmetic shift wrong");

   a_srp_both: assert property (
      srp_exec && src_q[1:0] == 2'b00 |=>
      rp0_q[7:3] == {$past(src_q[7:4]), 1'b0} && rp1_q[7:3] == {$past(src_q[7:4]), 1'b1})
      else $error("pointer load both wrong");

   a_srp_single: assert property (
      srp_exec && src_q[1:0] == 2'b10 |=>
      rp0_q[7:3] == $past(src_q[7:3]) && $stable(rp1_q))
      else $error("pointer load single wrong");

   a_srp_none: assert property (
      srp_exec && src_q[1:0] == 2'b11 |=> $stable(rp0_q) && $stable(rp1_q))
      else $error("pointer load changed on undefined pattern");

   a_stop_hold: assert property (
      stopped && !ext_irq |=> stopped && $stable(dst_q) && $stable(rp0_q) &&
      $stable(flg_q) && !cpu_clk_en)
      else $error("stop mode state changed");

endmodule : cspso_core
`default_nettype wire

// ### testbench/cspso_core_tb.sv
// self-checking testbench for the shift, subtract and pointer execution block
// assumes cspso_pkg and rtl/cspso_core.sv are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module cspso_core_tb
   import cspso_pkg::*;
;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, rsp;
   logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready, ext_irq, cpu_clk_en, sys_clk_en, stopped;
   int                miscompares, total_checks;
   int                cycles = 0;

   cspso_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_irq(ext_irq),
      .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .stopped(stopped));

   // ************************************************************
   // compare, bus and closing tasks
   // ************************************************************
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      chk_reg({30'h0, got}, {30'h0, exp});
   endtask : chk_resp

   task automatic chk_bit(input logic got, input logic exp);
      chk_reg({31'h0, got}, {31'h0, exp});
   endtask : chk_bit

   task automatic wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            resp = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : wr

   task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : rd

   task automatic wreg(input logic [9:0] idx, input logic [7:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      chk_resp(r, RESP_OKAY);
   endtask : wreg

   task automatic rreg(input logic [9:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(idx, d, r);
      chk_resp(r, RESP_OKAY);
      chk_reg(d, {24'h0, exp});
   endtask : rreg

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : do_reset

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset_map();
      logic [31:0] d;
      logic [1:0]  r;
      rreg(IDX_DST, RST_DST);
      rreg(IDX_FLG, RST_FLG);
      rreg(IDX_RP0, RST_RP0);
      rreg(IDX_RP1, RST_RP1);
      wreg(IDX_RP0, 8'h38);
      rreg(IDX_RP0, 8'h38);
      rreg(IDX_RP1, 8'h00);
      wr(10'h010, 8'h11, r);
      chk_resp(r, RESP_DECERR);
      rd(10'h010, d, r);
      chk_resp(r, RESP_DECERR);
      chk_reg(d, 32'h0000_0000);
      // a write with byte lane zero disabled is answered but leaves the register alone
      wstrb <= 4'h0;
      wr(IDX_RP1, 8'h55, r);
      wstrb <= 4'hF;
      chk_resp(r, RESP_OKAY);
      rreg(IDX_RP1, 8'h00);
   endtask : t_reset_map

   task automatic t_subtract();
      logic [27:0] tbl [8] = '{{OP_SUB, 8'h21, 8'h90, 8'h80}, {OP_SUB, 8'h21, 8'h65, 8'h00},
                              {OP_SUB, 8'h12, 8'h03, 8'h80}, {OP_SUB, 8'h05, 8'h05, 8'h00},
                              {OP_SBC, 8'h10, 8'h03, 8'h80}, {OP_SBC, 8'h20, 8'h8A, 8'h80},
                              {OP_SBC, 8'h00, 8'h00, 8'h80}, {OP_SBC, 8'h7F, 8'hFF, 8'h00}};
      logic [3:0] op;
      logic [7:0] d, s, f, r;
      logic [8:0] t;
      logic [4:0] n;
      logic       ci, v;
      for (int i = 0; i < 8; i++) begin
         {op, d, s, f} = tbl[i];
         ci = (op == OP_SBC) ? f[7] : 1'b0;
         t = {1'b0, d} - {1'b0, s} - {8'h0, ci};
         n = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, ci};
         r = t[7:0];
         v = (d[7] != s[7]) && (r[7] == s[7]);
         wreg(IDX_DST, d);
         wreg(IDX_SRC, s);
         wreg(IDX_FLG, f);
         wreg(IDX_CMD, {4'h0, op});
         rreg(IDX_DST, r);
         rreg(IDX_SRC, s);
         rreg(IDX_FLG, {t[8], r == 8'h00, r[7], v, 1'b1, n[4], 2'b00});
      end
   endtask : t_subtract

   task automatic t_carry_force();
      logic [7:0] fl [3] = '{8'h00, 8'h7C, 8'hD4};
      foreach (fl[i]) begin
         wreg(IDX_DST, 8'h3C);
         wreg(IDX_FLG, fl[i]);
         wreg(IDX_CMD, {4'h0, OP_SCF});
         rreg(IDX_FLG, fl[i] | 8'h80);
         rreg(IDX_DST, 8'h3C);
         rreg(IDX_CMD, {4'h0, OP_SCF});
      end
   endtask : t_carry_force

   task automatic t_shift();
      logic [7:0] dv [4] = '{8'h9A, 8'hBC, 8'h01, 8'h7E};
      logic [7:0] r;
      foreach (dv[i]) begin
         r = {dv[i][7], dv[i][7:1]};
         wreg(IDX_DST, dv[i]);
         wreg(IDX_FLG, (i % 2 == 0) ? 8'h5C : 8'hA0);
         wreg(IDX_CMD, {4'h0, OP_SRA});
         rreg(IDX_DST, r);
         rreg(IDX_FLG, {dv[i][0], r == 8'h00, r[7], 1'b0, (i % 2 == 0), (i % 2 == 0), 2'b00});
      end
   endtask : t_shift

   task automatic t_pointer();
      logic [7:0] sv [5] = '{8'h40, 8'h52, 8'h69, 8'h0B, 8'hF8};
      logic [7:0] p0, p1;
      for (int op = 5; op <= 7; op++) begin
         p0 = 8'h07;
         p1 = 8'h05;
         wreg(IDX_RP0, p0);
         wreg(IDX_RP1, p1);
         foreach (sv[i]) begin
            case (sv[i][1:0])
               2'b10: p0 = {sv[i][7:3], p0[2:0]};
               2'b01: p1 = {sv[i][7:3], p1[2:0]};
               2'b00: begin
                  p0 = {sv[i][7:4], 1'b0, p0[2:0]};
                  p1 = {sv[i][7:4], 1'b1, p1[2:0]};
               end
               default: ;
            endcase
            wreg(IDX_SRC, sv[i]);
            wreg(IDX_CMD, op[7:0]);
            rreg(IDX_RP0, p0);
            rreg(IDX_RP1, p1);
         end
      end
   endtask : t_pointer

   task automatic t_stop();
      wreg(IDX_DST, 8'h5A);
      wreg(IDX_RP1, 8'h68);
      wreg(IDX_CMD, {4'h0, OP_STOP});
      @(posedge aclk);
      chk_bit(stopped, 1'b1);
      chk_bit(cpu_clk_en, 1'b0);
      chk_bit(sys_clk_en, 1'b0);
      rreg(IDX_STAT, 8'h01);
      wr(IDX_DST, 8'hA5, rsp);
      chk_resp(rsp, RESP_SLVERR);
      repeat (6) @(posedge aclk);
      rreg(IDX_DST, 8'h5A);
      rreg(IDX_RP1, 8'h68);
      chk_bit(stopped, 1'b1);
      ext_irq <= 1'b1;
      @(posedge aclk);
      ext_irq <= 1'b0;
      @(posedge aclk);
      chk_bit(stopped, 1'b0);
      chk_bit(cpu_clk_en, 1'b1);
      rreg(IDX_DST, 8'h5A);
      wreg(IDX_CMD, {4'h0, OP_STOP});
      @(posedge aclk);
      chk_bit(stopped, 1'b1);
      do_reset();
      @(posedge aclk);
      chk_bit(stopped, 1'b0);
      chk_bit(sys_clk_en, 1'b1);
      rreg(IDX_DST, RST_DST);
   endtask : t_stop

   // ************************************************************
   // clock, timeout and main sequence
   // ************************************************************
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // the whole run needs about seven hundred cycles
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   initial begin
      miscompares = 0;
      total_checks = 0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      ext_irq = 1'b0;
      do_reset();
      t_reset_map();
      t_subtract();
      t_carry_force();
      t_shift();
      t_pointer();
      t_stop();
      wrap_up();
   end
endmodule : cspso_core_tb
`default_nettype wire
